// ===== radio_interrupt_logic.sv
// top of the radio interrupt logic with its axi4-lite register slave
module radio_interrupt_logic
  import irq_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event sources from the radio core
  input wire event_type events,
  input wire logic tx_busy,
  input wire logic buf_read_active,
  input wire logic buf_empty,
  // outputs to pins and core
  output logic irq_out,
  output logic amp_off_r
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_one_r;
  logic [7:0] mask_r;
  logic [7:0] flags;
  event_type sw_event_r;
  event_type all_events;
  flag_cfg_type cfg;
  logic status_clear;

  // write channel state
  logic [7:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic do_write;

  // read channel state
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  logic read_take;

  // mapped-address check for the write response; the read mux decodes its own default
  function automatic logic mapped(input logic [7:0] a);
    return a == CTRL_ONE_ADDR || a == MASK_ADDR || a == STATUS_ADDR ||
           a == EVENT_ADDR || a == MISC_ADDR;
  endfunction

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  assign s_axi_awready = ce && !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held_r && !s_axi_bvalid;
  assign do_write = ce && aw_held_r && w_held_r && !s_axi_bvalid;

  // hold address until both halves arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // hold data until both halves arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // only the low byte lane carries control and mask register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_r <= CTRL_ONE_RESET;
      mask_r <= MASK_RESET;
    end else if (ce && do_write && wstrb_r[0]) begin
      if (awaddr_r == CTRL_ONE_ADDR) begin
        ctrl_one_r <= wdata_r[7:0];
      end
      if (awaddr_r == MASK_ADDR) begin
        mask_r <= wdata_r[7:0];
      end
    end
  end

  // software event injection: one-cycle strobes, handy for bring-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_event_r <= '0;
    end else if (ce) begin
      if (do_write && awaddr_r == EVENT_ADDR && wstrb_r[0] && wstrb_r[1]) begin
        sw_event_r <= event_type'(wdata_r[NUM_EVENTS-1:0]);
      end else begin
        sw_event_r <= '0;
      end
    end
  end

  assign all_events = events | sw_event_r;
  assign cfg.mask = mask_r;
  assign cfg.poll_mode = ctrl_one_r[POLL_MODE_BIT];

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign read_take = s_axi_arvalid && s_axi_arready;
  // reading status clears every flag with no new event in the same edge the data is caught
  assign status_clear = read_take && s_axi_araddr == STATUS_ADDR;

  // read data mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = RESP_OKAY;
    unique case (s_axi_araddr)
      CTRL_ONE_ADDR: rdata_nxt[7:0] = ctrl_one_r;
      MASK_ADDR: rdata_nxt[7:0] = mask_r;
      STATUS_ADDR: rdata_nxt[7:0] = flags;
      MISC_ADDR: rdata_nxt[1:0] = {amp_off_r, irq_out};
      EVENT_ADDR: rdata_nxt = 32'h0000_0000;
      default: rresp_nxt = RESP_SLVERR;
    endcase
  end

  // registered read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (read_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // flags and pin
  // ------------------------------------------------------------
  irq_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .events(all_events),
    .cfg(cfg),
    .clear(status_clear),
    .flags_r(flags)
  );

  irq_pin u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .flags(flags),
    .mask(mask_r),
    .polarity(ctrl_one_r[POLARITY_BIT]),
    .empty_ind_en(ctrl_one_r[EMPTY_IND_BIT]),
    .buf_read_active(buf_read_active),
    .buf_empty(buf_empty),
    .irq_out_r(irq_out)
  );

  // amplifier shut off at once on unlock while transmitting; released on lock or whenever tx_busy is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_off_r <= 1'b0;
    end else if (ce) begin
      if (all_events.pll_unlock_event && tx_busy) begin
        amp_off_r <= 1'b1;
      end else if (all_events.pll_lock_event || !tx_busy) begin
        amp_off_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  reset_mask_a: assert property (@(posedge aclk)
    !aresetn |=> mask_r == 8'h00 && ctrl_one_r[POLL_MODE_BIT] && !ctrl_one_r[POLARITY_BIT])
    else $error("reset values of mask or control wrong");
  amp_cut_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && all_events.pll_unlock_event && tx_busy |=> amp_off_r)
    else $error("amplifier not switched off on unlock");
  status_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && read_take && s_axi_araddr == STATUS_ADDR
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(flags))
    else $error("status read data wrong");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  write_cover_c: cover property (@(posedge aclk) do_write && awaddr_r == MASK_ADDR);
  read_cover_c: cover property (@(posedge aclk) status_clear && flags != 8'h00);
  amp_cover_c: cover property (@(posedge aclk) amp_off_r);
endmodule

// ===== irq_pkg.sv
// package: register map, field positions, reset values and carrier types
package irq_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h10;    // transceiver_control_register_one
  localparam logic [7:0] MASK_ADDR = 8'h38;        // interrupt enable mask
  localparam logic [7:0] STATUS_ADDR = 8'h3C;      // interrupt status, clear on read
  localparam logic [7:0] EVENT_ADDR = 8'h40;       // event injection, write only
  localparam logic [7:0] MISC_ADDR = 8'h44;        // misc state readback
  localparam logic [7:0] CTRL_ONE_RESET = 8'h22;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POLARITY_BIT = 0;
  localparam int POLL_MODE_BIT = 1;
  localparam int EMPTY_IND_BIT = 7;   // frame-buffer-empty indicator enable, spare bit
  localparam int BIT_PLL_LOCK = 0;
  localparam int BIT_PLL_UNLOCK = 1;
  localparam int BIT_RX_START = 2;
  localparam int BIT_FRAME_DONE = 3;
  localparam int BIT_MEASURE = 4;
  localparam int BIT_ADDR_MATCH = 5;
  localparam int BIT_VIOLATION = 6;
  localparam int BIT_SUPPLY_LOW = 7;
  localparam int NUM_EVENTS = 9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // nine event strobes from the radio core
  typedef struct packed {
    logic supply_low_event;
    logic buffer_access_violation_event;
    logic address_match_event;
    logic channel_measure_done_event;
    logic wake_complete_event;
    logic frame_complete_event;
    logic rx_start_event;
    logic pll_unlock_event;
    logic pll_lock_event;
  } event_type;

  // configuration seen by the flag logic
  typedef struct packed {
    logic [7:0] mask;
    logic poll_mode;
  } flag_cfg_type;
endpackage

// ===== irq_flags.sv
// sticky status flags with mask, polling mode and clear-on-read
module irq_flags
  import irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // events and control
  input wire event_type events,
  input wire flag_cfg_type cfg,
  input wire logic clear,
  // state
  output logic [7:0] flags_r
);
  logic [7:0] raw;
  logic [7:0] rec;
  logic [7:0] flags_nxt;

  // fold nine events into eight bits; bit 4 shared by two functions
  always_comb begin
    raw = 8'h00;
    raw[BIT_SUPPLY_LOW] = events.supply_low_event;
    raw[BIT_VIOLATION] = events.buffer_access_violation_event;
    raw[BIT_ADDR_MATCH] = events.address_match_event;
    raw[BIT_MEASURE] = events.channel_measure_done_event | events.wake_complete_event;
    raw[BIT_FRAME_DONE] = events.frame_complete_event;
    raw[BIT_RX_START] = events.rx_start_event;
    raw[BIT_PLL_UNLOCK] = events.pll_unlock_event;
    raw[BIT_PLL_LOCK] = events.pll_lock_event;
  end

  // masked events recorded only in polling mode
  assign rec = cfg.poll_mode ? raw : (raw & cfg.mask);

  // set wins over clear; pll pair cancels each other
  always_comb begin
    flags_nxt = (clear ? 8'h00 : flags_r) | rec;
    if (rec[BIT_PLL_LOCK] && !rec[BIT_PLL_UNLOCK]) begin
      flags_nxt[BIT_PLL_UNLOCK] = 1'b0;
    end
    if (rec[BIT_PLL_UNLOCK] && !rec[BIT_PLL_LOCK]) begin
      flags_nxt[BIT_PLL_LOCK] = 1'b0;
    end
  end

  // status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= STATUS_RESET;
    end else if (ce) begin
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !clear && rec == 8'h00 |=> flags_r == $past(flags_r))
    else $error("flag changed without event or clear");
  read_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && clear && rec == 8'h00 |=> flags_r == 8'h00)
    else $error("status read did not clear flags");
  set_beats_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && clear && rec[BIT_VIOLATION] |=> flags_r[BIT_VIOLATION])
    else $error("event lost against clear");
  pll_exclusive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rec[BIT_PLL_LOCK] && !rec[BIT_PLL_UNLOCK] |=> !flags_r[BIT_PLL_UNLOCK])
    else $error("lock did not clear unlock");
  no_record_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cfg.poll_mode && cfg.mask == 8'h00 && (clear || flags_r == 8'h00)
    |=> flags_r == 8'h00)
    else $error("event recorded with zero mask");
  poll_record_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg.poll_mode && events.wake_complete_event |=> flags_r[BIT_MEASURE])
    else $error("polled event not recorded");
  shared_cover_c: cover property (@(posedge aclk) events.wake_complete_event && cfg.mask[4]);
endmodule

// ===== irq_pin.sv
// interrupt pin driver: or of enabled flags, polarity, indicator override
module irq_pin
  import irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // state and config
  input wire logic [7:0] flags,
  input wire logic [7:0] mask,
  input wire logic polarity,
  input wire logic empty_ind_en,
  input wire logic buf_read_active,
  input wire logic buf_empty,
  // pin
  output logic irq_out_r
);
  logic pending;

  // only enabled flags reach the pin, whatever the polling mode
  assign pending = |(flags & mask);

  // registered pin; indicator is always active high and ignores polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out_r <= 1'b0;
    end else if (ce) begin
      if (empty_ind_en && buf_read_active) begin
        irq_out_r <= buf_empty;
      end else begin
        irq_out_r <= pending ^ polarity;
      end
    end
  end

  pin_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !(empty_ind_en && buf_read_active) |=> irq_out_r == ($past(pending) ^ $past(polarity)))
    else $error("interrupt pin level wrong");
  pin_cover_c: cover property (@(posedge aclk) ce && pending && polarity);
endmodule

// ===== irq_host_model.sv
// host model: axi4-lite master tasks and interrupt service read
module irq_host_model
  import irq_pkg::*;
(
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  // interrupt pin
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // bus master
  // ------------------------------------------------------------
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // aw and w offered together, each dropped when taken; payload inverted after
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 0;
        s_axi_wdata <= ~d;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // read: hold arvalid until taken, rready until rvalid seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready === 1'b1));
    s_axi_arvalid <= 0;
    s_axi_araddr <= ~a;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // waits a short while for the pin, then reads status to find the source
  task automatic service(input logic pol, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    while (irq_out === pol && n < 8) begin
      @(posedge aclk);
      n++;
    end
    rd(STATUS_ADDR, d, r);
  endtask
endmodule

// ===== radio_interrupt_logic_tb.sv
// testbench for the radio interrupt logic
module radio_interrupt_logic_tb
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask;
    event_type ev;
    logic [7:0] st;
    logic act;
  } row_type;
  // one row per event, then the mask and polling combinations
  localparam row_type ROWS [13] = '{
    '{8'h22, 8'hff, 9'h100, 8'h80, 1'b1}, '{8'h22, 8'hff, 9'h080, 8'h40, 1'b1},
    '{8'h22, 8'hff, 9'h040, 8'h20, 1'b1}, '{8'h22, 8'hff, 9'h020, 8'h10, 1'b1},
    '{8'h22, 8'hff, 9'h010, 8'h10, 1'b1}, '{8'h22, 8'hff, 9'h008, 8'h08, 1'b1},
    '{8'h22, 8'hff, 9'h004, 8'h04, 1'b1}, '{8'h22, 8'hff, 9'h002, 8'h02, 1'b1},
    '{8'h22, 8'hff, 9'h001, 8'h01, 1'b1}, '{8'h20, 8'h00, 9'h100, 8'h00, 1'b0},
    '{8'h22, 8'h00, 9'h100, 8'h80, 1'b0}, '{8'h20, 8'h01, 9'h101, 8'h01, 1'b1},
    '{8'h23, 8'h80, 9'h100, 8'h80, 1'b1}};
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1;
  event_type events = '0;
  logic tx_busy = 0, buf_read_active = 0, buf_empty = 0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_out, amp_off_r;
  logic [31:0] d;
  logic [1:0] r;
  int bad_count = 0;
  int n_tests = 0;
  // 200 mhz clock
  always #2.5 aclk = ~aclk;
  radio_interrupt_logic radio_interrupt_logic_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .tx_busy(tx_busy), .buf_read_active(buf_read_active),
    .buf_empty(buf_empty), .irq_out(irq_out), .amp_off_r(amp_off_r));
  irq_host_model host_i (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_out(irq_out));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one-cycle event strobe
  task automatic pulse(input event_type e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask
  // program ctrl and mask, then read status to clear the history
  task automatic setup(input logic [7:0] c, input logic [7:0] m);
    host_i.wr(CTRL_ONE_ADDR, 32'(c), r);
    host_i.wr(MASK_ADDR, 32'(m), r);
    host_i.rd(STATUS_ADDR, d, r);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 13; i++) begin
      setup(ROWS[i].ctrl, ROWS[i].mask);
      pulse(ROWS[i].ev);
      repeat (3) @(posedge aclk);
      chk(irq_out, ROWS[i].act ^ ROWS[i].ctrl[0], "pin level");
      host_i.service(ROWS[i].ctrl[0], d, r);
      chk(d, ROWS[i].st, "status");
      repeat (2) @(posedge aclk);
      chk(irq_out, ROWS[i].ctrl[0], "pin after read");
      $display("row %0d done", i);
    end
    // pll pair: the later one wins
    setup(8'h22, 8'hff);
    pulse(9'h001);
    pulse(9'h002);
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'h0000_0002, "unlock over lock");
    pulse(9'h002);
    pulse(9'h001);
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'h0000_0001, "lock over unlock");
    $display("pll pair done");
    // event landing in the cycle of the clearing read must survive
    pulse(9'h008);
    fork
      host_i.rd(STATUS_ADDR, d, r);
      begin
        @(posedge aclk);
        events <= 9'h040;
        @(posedge aclk);
        events <= '0;
      end
    join
    chk(d, 32'h0000_0008, "pre clear data");
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'h0000_0020, "same cycle event");
    $display("clear race done");
    // unmapped address and event injection
    host_i.rd(8'h80, d, r);
    chk(r, RESP_SLVERR, "unmapped read resp");
    chk(d, 32'h0000_0000, "unmapped read data");
    host_i.wr(8'h80, 32'h0000_0001, r);
    chk(r, RESP_SLVERR, "unmapped write resp");
    host_i.wr(EVENT_ADDR, 32'h0000_0100, r);
    chk(r, RESP_OKAY, "event write resp");
    repeat (3) @(posedge aclk);
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'h0000_0080, "injected event");
    $display("bus cases done");
    // empty indicator overrides the pin, active high even with polarity inverted
    setup(8'ha3, 8'h00);
    @(posedge aclk);
    buf_read_active <= 1;
    buf_empty <= 1;
    repeat (3) @(posedge aclk);
    chk(irq_out, 1'b1, "indicator empty");
    buf_empty <= 0;
    repeat (3) @(posedge aclk);
    chk(irq_out, 1'b0, "indicator not empty");
    buf_read_active <= 0;
    // unlock while transmitting switches the amplifier off
    tx_busy <= 1;
    pulse(9'h002);
    repeat (2) @(posedge aclk);
    chk(amp_off_r, 1'b1, "amp off on unlock");
    pulse(9'h001);
    repeat (2) @(posedge aclk);
    chk(amp_off_r, 1'b0, "amp back on lock");
    tx_busy <= 0;
    $display("indicator and amplifier done");
    // clock enable low freezes the flags, so an event then is not recorded
    setup(8'h22, 8'hff);
    ce <= 1'b0;
    pulse(9'h100);
    @(posedge aclk);
    ce <= 1'b1;
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'h0000_0000, "frozen by enable");
    $display("clock enable done");
    // mid-run reset with flags pending and polarity flipped
    setup(8'h23, 8'hff);
    pulse(9'h100);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk(irq_out, 1'b0, "pin after reset");
    host_i.rd(CTRL_ONE_ADDR, d, r);
    chk(d, 32'(CTRL_ONE_RESET), "ctrl reset");
    host_i.rd(MASK_ADDR, d, r);
    chk(d, 32'(MASK_RESET), "mask reset");
    host_i.rd(STATUS_ADDR, d, r);
    chk(d, 32'(STATUS_RESET), "status reset");
    $display("reset done");
    finish_test();
  end
endmodule
